// ### hw/cps_pkg.sv
package cps_pkg;

   // ==========================================================
   // Target power state codes.
   localparam logic [2:0] MODE_NORMAL = 3'h0;
   localparam logic [2:0] MODE_SYSCLK_OFF = 3'h1;
   localparam logic [2:0] MODE_PLL_OFF_REQ = 3'h2;
   localparam logic [2:0] MODE_ALL_OFF = 3'h3;

   // ==========================================================
   // Timing.
   localparam int CLK_MHZ = 100;
   localparam int WAKE_MAX_US = 2000;
   localparam int WAKE_MAX_CYC = WAKE_MAX_US * CLK_MHZ;
   localparam int PLL_LOCK_US = 100;
   localparam int PLL_LOCK_CYC = PLL_LOCK_US * CLK_MHZ;
   localparam int XTAL_START_US = 1000;
   localparam int XTAL_START_CYC = XTAL_START_US * CLK_MHZ;
   localparam int DIS_WRITES = 2;
   localparam int SYNC_STAGES = 2;

   typedef enum {
      CPS_RUN,
      CPS_SLEEP,
      CPS_XTAL_WAIT,
      CPS_PLL_WAIT
   } cps_state_t;

endpackage

// ### hw/cps_wake_sync.sv
`timescale 1ns/100ps
module cps_wake_sync (
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic rstn,
   // Host activity strobe, may arrive with the clock stopped, and its clear.
   input wire logic wake_strobe,
   input wire logic clear,
   // Synchronised wake request.
   output logic wake_seen
);

   // ==========================================================
   // Asynchronous capture of the host strobe.
   logic captured;
   logic sync1;
   logic sync2;

   always_ff @(posedge wake_strobe or posedge clear) begin
      if (clear) begin
         captured <= 1'b0;
      end else begin
         captured <= 1'b1;
      end
   end

   // ==========================================================
   // Resynchronisation to the restarted clock.
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         sync1 <= 1'b0;
         sync2 <= 1'b0;
      end else begin
         sync1 <= captured;
         sync2 <= sync1;
      end
   end

   assign wake_seen = sync2;

endmodule

// ### hw/cps_ctrl.sv
`timescale 1ns/100ps
// What this block does
// - Core clock disable needs two consecutive 1-writes.
// - Gating freezes a module, never resets it.
// - LED disable releases open LEDs, push-pull inactive.
// - Settings other than mode and sleep survive every power state.
// - Any chip reset returns to normal state.
// - Sysclk-off state: system clocks stop, PLL runs.
// - PLL-off state: PLL off only if PHYs down.
// - All-off state: PLL, crystal, network clocks off.
// - All-off state wakes only by host access.
// - Crystal off also stops reference clock out.
// - Sleep ignored when written with mode change.
// - Entering saving state drops ready low.
// - Host interfaces dead while saving, except wake.
// - Auto wake on pending event when enabled.
// - Parallel bus write strobe wakes the chip.
// - Serial select low with clock high wakes.
// - Ready rises after PLL lock; clears mode, sleep.
// - Wake completes within two milliseconds.
// - Mode codes 0 to 3; 4 to 7 reserved.
// - Wake event is masked port status ORed.
// - Auto wake ignores wake pin settings.
module cps_ctrl #(
   parameter int NUM_LEDS = 4,
   parameter int XTAL_CYC = cps_pkg::XTAL_START_CYC,
   parameter int PLL_CYC = cps_pkg::PLL_LOCK_CYC
) (
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic rstn,
   // Control register write port.
   input wire logic ctrl_wr,
   input wire logic [2:0] wr_target_power_state,
   input wire logic wr_sleep_request,
   input wire logic wr_auto_wake_enable,
   input wire logic wr_led_output_disable,
   input wire logic wr_core_clock_disable,
   // Wake event sources and PHY state.
   input wire logic [1:0] port_wake_status,
   input wire logic [1:0] port_wake_enable,
   input wire logic phy_a_low_power,
   input wire logic phy_b_low_power,
   // Host access pins.
   input wire logic host_bus_cs,
   input wire logic host_bus_wr,
   input wire logic host_bus_rd_wr,
   input wire logic host_bus_enb,
   input wire logic serial_chip_select_n,
   input wire logic serial_clk,
   // LED requests and pad controls.
   input wire logic [NUM_LEDS-1:0] led_on,
   input wire logic [NUM_LEDS-1:0] led_push_pull,
   input wire logic [NUM_LEDS-1:0] led_active_high,
   output logic [NUM_LEDS-1:0] led_out,
   output logic [NUM_LEDS-1:0] led_oe_n,
   // Status.
   output logic [2:0] target_power_state,
   output logic sleep_request,
   output logic auto_wake_enable,
   output logic led_output_disable,
   output logic core_clock_disable,
   output logic ready,
   output logic wake_event,
   output logic host_if_enable,
   // Clock gates.
   output logic sysclk_enable,
   output logic core_clk_enable,
   output logic pll_enable,
   output logic xtal_enable,
   output logic clk25_out_enable,
   output logic netclk_enable
);

   // ==========================================================
   // State and registers.
   cps_pkg::cps_state_t state;
   cps_pkg::cps_state_t next_state;
   logic [2:0] sleep_mode;
   logic dis_count;
   logic [31:0] wait_cnt;
   logic wake_clear;
   logic manual_wake;

   // ==========================================================
   // Decodes.
   wire mode_change = wr_target_power_state != target_power_state;
   wire mode_valid = target_power_state <= cps_pkg::MODE_ALL_OFF;
   wire sleep_go = ctrl_wr && wr_sleep_request && !mode_change && mode_valid
      && target_power_state != cps_pkg::MODE_NORMAL;
   wire host_bus_strobe = host_bus_cs && (host_bus_wr || (host_bus_rd_wr && host_bus_enb));
   wire spi_strobe = !serial_chip_select_n && serial_clk;
   wire auto_ok = auto_wake_enable && wake_event && sleep_mode != cps_pkg::MODE_ALL_OFF;
   wire in_run = state == cps_pkg::CPS_RUN;
   wire in_sleep = state == cps_pkg::CPS_SLEEP;
   wire wait_done = wait_cnt == 32'h0;
   wire two_phy_down = phy_a_low_power && phy_b_low_power;

   assign wake_event = |(port_wake_status & port_wake_enable);

   // ==========================================================
   // Manual wake capture.
   assign wake_clear = in_run;

   cps_wake_sync u_wake (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .wake_strobe(host_bus_strobe || spi_strobe),
      .clear(wake_clear),
      .wake_seen(manual_wake)
   );

   // ==========================================================
   // Power state machine.
   always_comb begin
      next_state = state;
      case (state)
         cps_pkg::CPS_RUN: begin
            if (sleep_go) begin
               next_state = cps_pkg::CPS_SLEEP;
            end
         end
         cps_pkg::CPS_SLEEP: begin
            if (manual_wake || auto_ok) begin
               if (sleep_mode == cps_pkg::MODE_ALL_OFF) begin
                  next_state = cps_pkg::CPS_XTAL_WAIT;
               end else begin
                  next_state = cps_pkg::CPS_PLL_WAIT;
               end
            end
         end
         cps_pkg::CPS_XTAL_WAIT: begin
            if (wait_done) begin
               next_state = cps_pkg::CPS_PLL_WAIT;
            end
         end
         cps_pkg::CPS_PLL_WAIT: begin
            if (wait_done) begin
               next_state = cps_pkg::CPS_RUN;
            end
         end
         default: begin
            next_state = cps_pkg::CPS_RUN;
         end
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         state <= cps_pkg::CPS_RUN;
      end else begin
         state <= next_state;
      end
   end

   // ==========================================================
   // Wake wait counter.
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         wait_cnt <= 32'h0;
      end else if (in_sleep && next_state == cps_pkg::CPS_XTAL_WAIT) begin
         wait_cnt <= 32'(XTAL_CYC - 1);
      end else if (next_state == cps_pkg::CPS_PLL_WAIT && state != cps_pkg::CPS_PLL_WAIT) begin
         wait_cnt <= 32'(PLL_CYC - 1);
      end else if (!wait_done) begin
         wait_cnt <= wait_cnt - 32'h1;
      end
   end

   // ==========================================================
   // Control register.
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         target_power_state <= cps_pkg::MODE_NORMAL;
         sleep_request <= 1'b0;
         sleep_mode <= cps_pkg::MODE_NORMAL;
      end else if (state == cps_pkg::CPS_PLL_WAIT && wait_done) begin
         target_power_state <= cps_pkg::MODE_NORMAL;
         sleep_request <= 1'b0;
      end else if (in_run && ctrl_wr) begin
         if (sleep_go) begin
            sleep_request <= 1'b1;
            sleep_mode <= target_power_state;
         end else if (!wr_sleep_request) begin
            target_power_state <= wr_target_power_state;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         auto_wake_enable <= 1'b0;
         led_output_disable <= 1'b0;
         core_clock_disable <= 1'b0;
         dis_count <= 1'b0;
      end else if (in_run && ctrl_wr) begin
         auto_wake_enable <= wr_auto_wake_enable;
         led_output_disable <= wr_led_output_disable;
         if (!wr_core_clock_disable) begin
            dis_count <= 1'b0;
            core_clock_disable <= 1'b0;
         end else if (dis_count) begin
            core_clock_disable <= 1'b1;
         end else begin
            dis_count <= 1'b1;
         end
      end
   end

   // ==========================================================
   // Outputs.
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         ready <= 1'b0;
      end else begin
         ready <= next_state == cps_pkg::CPS_RUN && !(in_run && sleep_go);
      end
   end

   wire deep = in_sleep || state == cps_pkg::CPS_XTAL_WAIT;
   assign host_if_enable = in_run;
   assign sysclk_enable = in_run;
   assign core_clk_enable = in_run && !core_clock_disable;
   assign xtal_enable = !(deep && sleep_mode == cps_pkg::MODE_ALL_OFF);
   assign clk25_out_enable = xtal_enable;
   assign pll_enable = !(in_sleep && (sleep_mode == cps_pkg::MODE_ALL_OFF
      || (sleep_mode == cps_pkg::MODE_PLL_OFF_REQ && two_phy_down))) && xtal_enable;
   assign netclk_enable = xtal_enable;

   genvar i;
   generate
      for (i = 0; i < NUM_LEDS; i++) begin : g_led
         always_ff @(posedge clk_sys) begin
            if (!rstn) begin
               led_out[i] <= !led_active_high[i];
            end else begin
               led_out[i] <= (led_on[i] && !led_output_disable) == led_active_high[i];
            end
         end
         assign led_oe_n[i] = led_output_disable && !led_push_pull[i];
      end
   endgenerate

endmodule

// ### verif/cps_ctrl_sva.sv
`timescale 1ns/100ps
// ==========================================
// Power state checker.
module cps_ctrl_chk (
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic rstn,
   // Control writes and PHY state.
   input wire logic ctrl_wr,
   input wire logic [2:0] wr_target_power_state,
   input wire logic wr_sleep_request,
   input wire logic phy_a_low_power,
   input wire logic phy_b_low_power,
   // Status and clock gates.
   input wire logic [2:0] target_power_state,
   input wire logic sleep_request,
   input wire logic auto_wake_enable,
   input wire logic ready,
   input wire logic wake_event,
   input wire logic host_if_enable,
   input wire logic sysclk_enable,
   input wire logic pll_enable,
   input wire logic xtal_enable,
   input wire logic clk25_out_enable,
   input wire logic netclk_enable
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rstn);
   wire sl = ctrl_wr && host_if_enable && wr_sleep_request;
   wire sl_ok = sl && wr_target_power_state == target_power_state && wr_target_power_state inside {[3'h1:3'h3]};
   property p_ready_drop;
      sl_ok |=> !ready && sleep_request && !host_if_enable;
   endproperty
   a_ready_drop: assert property (p_ready_drop) else $error("ready kept after sleep");
   property p_mode_chg;
      sl && wr_target_power_state != target_power_state |=> !sleep_request && $stable(target_power_state);
   endproperty
   a_mode_chg: assert property (p_mode_chg) else $error("sleep taken with mode change");
   property p_d1;
      $rose(sleep_request) && target_power_state == 3'h1 |-> !sysclk_enable && pll_enable && xtal_enable;
   endproperty
   a_d1: assert property (p_d1) else $error("wrong gates in sysclk off state");
   property p_d2;
      $rose(sleep_request) && target_power_state == 3'h2
         |-> !sysclk_enable && xtal_enable && pll_enable != (phy_a_low_power && phy_b_low_power);
   endproperty
   a_d2: assert property (p_d2) else $error("wrong gates in pll off state");
   property p_d3;
      $rose(sleep_request) && target_power_state == 3'h3 |-> !sysclk_enable && !pll_enable && !xtal_enable && !netclk_enable;
   endproperty
   a_d3: assert property (p_d3) else $error("wrong gates in all off state");
   property p_ref;
      !xtal_enable |-> !clk25_out_enable;
   endproperty
   a_ref: assert property (p_ref) else $error("reference clock runs without crystal");
   property p_wake;
      $rose(ready) |-> target_power_state == 3'h0 && !sleep_request && host_if_enable;
   endproperty
   a_wake: assert property (p_wake) else $error("ready rose before state cleared");
   property p_auto;
      sleep_request && auto_wake_enable && wake_event && target_power_state != 3'h3 |-> ##[1:40] ready;
   endproperty
   a_auto: assert property (p_auto) else $error("no automatic wake");
endmodule
bind cps_ctrl cps_ctrl_chk u_chk (.*);

// ### verif/cps_host.sv
`timescale 1ns/100ps
// ==========================================
// Host pin driver: 1 strobe with write, 2 strobe with direction, 3 serial cycle.
module cps_host (
   // Clock and command.
   input wire logic clk_sys,
   input wire logic [1:0] kick,
   // Host pins.
   output logic host_bus_cs = 1'b0,
   output logic host_bus_wr = 1'b0,
   output logic host_bus_rd_wr = 1'b0,
   output logic host_bus_enb = 1'b0,
   output logic serial_chip_select_n = 1'b1,
   output logic serial_clk = 1'b0
);
   always @(posedge clk_sys) begin
      host_bus_cs <= kick == 2'h1 || kick == 2'h2;
      host_bus_wr <= kick == 2'h1;
      host_bus_rd_wr <= kick == 2'h2;
      host_bus_enb <= kick == 2'h2;
      serial_chip_select_n <= kick != 2'h3;
      serial_clk <= kick == 2'h3;
   end
endmodule

// ### verif/chip_power_state_control_test.sv
`timescale 1ns/100ps
// ==========================================
// Power state control testbench.
module chip_power_state_control_test;
   logic clk_sys = 1'b0;
   logic rstn = 1'b0;
   logic ctrl_wr = 1'b0;
   logic [2:0] wr_target_power_state = 3'h0;
   logic wr_sleep_request = 1'b0, wr_auto_wake_enable = 1'b0, wr_led_output_disable = 1'b0, wr_core_clock_disable = 1'b0;
   logic [1:0] port_wake_status = 2'h0, port_wake_enable = 2'h0, kick = 2'h0;
   logic phy_a_low_power = 1'b1, phy_b_low_power = 1'b1;
   logic [3:0] led_on = 4'hF, led_push_pull = 4'h3, led_active_high = 4'h5;
   logic [3:0] led_out, led_oe_n;
   logic [2:0] target_power_state;
   logic sleep_request, auto_wake_enable, led_output_disable, core_clock_disable, ready, wake_event, host_if_enable;
   logic sysclk_enable, core_clk_enable, pll_enable, xtal_enable, clk25_out_enable, netclk_enable;
   logic host_bus_cs, host_bus_wr, host_bus_rd_wr, host_bus_enb, serial_chip_select_n, serial_clk;
   int n_errors = 0, compares = 0;
   cps_ctrl #(.NUM_LEDS(4), .XTAL_CYC(5), .PLL_CYC(8)) uut (.*);
   cps_host host (.*);
   initial begin
      forever #5 clk_sys = ~clk_sys;
   end
   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr(input logic [2:0] m, input logic s, input logic a, input logic l, input logic c);
      {wr_target_power_state, wr_sleep_request, wr_auto_wake_enable, wr_led_output_disable, wr_core_clock_disable} <= {m, s, a, l, c};
      ctrl_wr <= 1'b1;
      @(posedge clk_sys);
      ctrl_wr <= 1'b0;
      @(posedge clk_sys);
   endtask
   task automatic t_core;
      wr(3'h0, 1'b0, 1'b0, 1'b0, 1'b1);
      wr(3'h0, 1'b0, 1'b0, 1'b0, 1'b0);
      wr(3'h0, 1'b0, 1'b0, 1'b0, 1'b1);
      chk("core_once", core_clock_disable, 1'b0);
      wr(3'h0, 1'b0, 1'b0, 1'b0, 1'b1);
      chk("core_twice", {core_clock_disable, core_clk_enable}, 2'h2);
      wr(3'h0, 1'b0, 1'b0, 1'b0, 1'b0);
      chk("core_clear", core_clock_disable, 1'b0);
      $display("core clock test done");
   endtask
   task automatic t_led;
      wr(3'h0, 1'b0, 1'b0, 1'b1, 1'b0);
      chk("led_release", led_oe_n, 4'hC);
      @(posedge clk_sys);
      chk("led_idle", led_out & 4'h3, 4'h2);
      wr(3'h0, 1'b0, 1'b0, 1'b0, 1'b0);
      $display("led test done");
   endtask
   task automatic t_refuse;
      wr(3'h2, 1'b0, 1'b0, 1'b0, 1'b0);
      wr(3'h3, 1'b1, 1'b0, 1'b0, 1'b0);
      chk("mode_chg", {target_power_state, sleep_request, ready}, {3'h2, 1'b0, 1'b1});
      wr(3'h5, 1'b0, 1'b0, 1'b0, 1'b0);
      wr(3'h5, 1'b1, 1'b0, 1'b0, 1'b0);
      chk("mode_reserved", {target_power_state, sleep_request, ready}, {3'h5, 1'b0, 1'b1});
      wr(3'h0, 1'b0, 1'b0, 1'b0, 1'b0);
      wr(3'h0, 1'b1, 1'b0, 1'b0, 1'b0);
      chk("mode_zero", {sleep_request, ready}, 2'h1);
      $display("refusal test done");
   endtask
   task automatic t_event;
      port_wake_status <= 2'h1;
      port_wake_enable <= 2'h2;
      @(posedge clk_sys);
      chk("event_masked", wake_event, 1'b0);
      port_wake_enable <= 2'h3;
      @(posedge clk_sys);
      chk("event_on", wake_event, 1'b1);
      $display("event test done");
   endtask
   task automatic t_sleep(input logic [2:0] m, input logic [1:0] k, input logic a);
      int n;
      wr(m, 1'b0, a, 1'b1, 1'b0);
      wr(m, 1'b1, a, 1'b1, 1'b0);
      chk("sleep_entry", {ready, host_if_enable, sleep_request}, 3'h1);
      chk("gates", {sysclk_enable, pll_enable, xtal_enable, clk25_out_enable, netclk_enable},
          {1'b0, m == 3'h1 || (m == 3'h2 && !(phy_a_low_power && phy_b_low_power)),
           m != 3'h3, m != 3'h3, m != 3'h3});
      if (m == 3'h3) begin
         repeat (30) @(posedge clk_sys);
         chk("no_auto", ready, 1'b0);
      end
      kick <= k;
      @(posedge clk_sys);
      kick <= 2'h0;
      for (n = 0; n < 40 && ready !== 1'b1; n++) @(posedge clk_sys);
      chk("awake", {ready, target_power_state, sleep_request, led_output_disable, auto_wake_enable},
          {1'b1, 3'h0, 1'b0, 1'b1, a});
      $display("sleep test done");
   endtask
   task automatic t_reset;
      wr(3'h1, 1'b0, 1'b0, 1'b0, 1'b0);
      wr(3'h1, 1'b1, 1'b0, 1'b0, 1'b0);
      rstn <= 1'b0;
      repeat (2) @(posedge clk_sys);
      rstn <= 1'b1;
      repeat (3) @(posedge clk_sys);
      chk("after_reset", {ready, target_power_state, sleep_request}, 5'h10);
      $display("reset test done");
   endtask
   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   initial begin
      repeat (5000) @(posedge clk_sys);
      n_errors++;
      print_verdict;
   end
   initial begin
      repeat (20) @(posedge clk_sys);
      rstn <= 1'b1;
      repeat (3) @(posedge clk_sys);
      t_core;
      t_led;
      t_refuse;
      t_event;
      t_sleep(3'h1, 2'h0, 1'b1);
      t_sleep(3'h3, 2'h3, 1'b1);
      port_wake_enable <= 2'h0;
      t_sleep(3'h2, 2'h1, 1'b0);
      phy_b_low_power <= 1'b0;
      t_sleep(3'h2, 2'h3, 1'b0);
      phy_b_low_power <= 1'b1;
      t_sleep(3'h1, 2'h2, 1'b0);
      t_reset;
      print_verdict;
   end
endmodule
